// [rtl/dso_status_outputs.sv]
`timescale 1ns/1ps
`default_nettype none

module dso_status_outputs (
    // clock and reset
    input  wire logic                          clock_i,
    input  wire logic                          nrst_i,
    // register port
    input  wire logic [dso_pkg::AW-1:0]        addr_i,
    input  wire logic [dso_pkg::DW-1:0]        wdata_i,
    input  wire logic                          wr_i,
    input  wire logic                          rd_i,
    output logic      [dso_pkg::DW-1:0]        rdata_o,
    // drive quantities
    input  wire logic [dso_pkg::FREQ_W-1:0]    out_freq_i,
    input  wire logic [dso_pkg::FREQ_W-1:0]    motor_speed_i,
    input  wire logic signed [15:0]            torque_i,
    input  wire logic                          reverse_i,
    input  wire logic [dso_pkg::HOURS_W-1:0]   cumulative_run_hours_i,
    input  wire logic [dso_pkg::HOURS_W-1:0]   cumulative_power_hours_i,
    input  wire logic                          tripped_i,
    input  wire logic [dso_pkg::TF_W-1:0]      trip_factor_i,
    // terminals
    output logic      [dso_pkg::NTERM-1:0]     term_o,
    output logic                               relay_o
);
    import dso_pkg::*;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // picks the status signal that a selector code names
    function automatic logic pick(input logic [SEL_W-1:0] code, input logic [4:0] fl);
        logic r;
        r = 1'b0;
        if (code == FN_RNT) r = fl[0];
        else if (code == FN_ONT) r = fl[1];
        else if (code == FN_ZS) r = fl[2];
        else if (code == FN_OTQ) r = fl[3];
        else if (code == FN_ALARM) r = fl[4];
        return r;
    endfunction

    // saturates a written word at its documented top; the whole word is
    // compared so that high bits clip instead of wrapping to a small value
    function automatic logic [DW-1:0] sat_word(input logic [DW-1:0] v,
                                               input logic [DW-1:0] top);
        return (v > top) ? top : v;
    endfunction

    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    logic [SEL_W-1:0]  sel_reg [NSEL];
    logic [LIM_W-1:0]  lim_val_reg;
    logic              lim_unit_reg;
    logic [FREQ_W-1:0] zs_thr_reg;
    logic [TQ_W-1:0]   tq_lim_reg [4];
    logic [2:0]        curve_reg;
    logic [1:0]        trip_w_reg;

    // ----------------------------------------------------------------
    // status and output registers
    // ----------------------------------------------------------------
    logic              run_over_reg;
    logic              power_over_reg;
    logic              zero_speed_reg;
    logic              overtorque_reg;
    logic [3:0]        alarm_code_reg;
    logic [NTERM-1:0]  term_reg;
    logic              relay_reg;
    logic [DW-1:0]     rdata_reg;

    // ----------------------------------------------------------------
    // write decode
    // ----------------------------------------------------------------
    logic [NSEL-1:0]   wr_sel;
    logic [3:0]        wr_tq;
    wire               wr_lim   = wr_i && (addr_i == ADDR_HOURS_LIM);
    wire               wr_zs    = wr_i && (addr_i == ADDR_ZS_THR);
    wire               wr_curve = wr_i && (addr_i == ADDR_CURVE);
    wire               wr_tw    = wr_i && (addr_i == ADDR_TRIP_W);

    // one selector per terminal plus the relay
    genvar gi;
    generate
        for (gi = 0; gi < NSEL; gi++) begin : g_sel
            assign wr_sel[gi] = wr_i &&
                (addr_i == ADDR_SEL_BASE + 8'(gi) * ADDR_SEL_STRIDE);
            always_ff @(posedge clock_i or negedge nrst_i) begin
                if (!nrst_i) sel_reg[gi] <= '0;
                else if (wr_sel[gi]) sel_reg[gi] <= wdata_i[SEL_W-1:0];
            end
        end
        for (gi = 0; gi < 4; gi++) begin : g_tq
            assign wr_tq[gi] = wr_i &&
                (addr_i == ADDR_TQ_BASE + 8'(gi) * ADDR_SEL_STRIDE);
            always_ff @(posedge clock_i or negedge nrst_i) begin
                if (!nrst_i) tq_lim_reg[gi] <= '0;
                else if (wr_tq[gi])
                    tq_lim_reg[gi] <= TQ_W'(sat_word(wdata_i, DW'(TQ_LIM_MAX)));
            end
        end
    endgenerate

    // scalar settings; the zero-speed threshold clips rather than wraps, the hours limit keeps only its low bits
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            lim_val_reg  <= '0;
            lim_unit_reg <= 1'b0;
            zs_thr_reg   <= '0;
            curve_reg    <= CURVE_VC;
            trip_w_reg   <= TW_OFF;
        end else begin
            if (wr_lim) begin
                lim_val_reg  <= wdata_i[LIM_W-1:0];
                lim_unit_reg <= wdata_i[UNIT_BIT];
            end
            if (wr_zs) zs_thr_reg <= FREQ_W'(sat_word(wdata_i, DW'(ZS_THR_MAX)));
            if (wr_curve) curve_reg <= wdata_i[2:0];
            if (wr_tw) trip_w_reg <= wdata_i[1:0];
        end
    end

    // ----------------------------------------------------------------
    // hours warnings
    // ----------------------------------------------------------------
    wire [HOURS_W-1:0] lim_hours = HOURS_W'(lim_val_reg) *
        (lim_unit_reg ? HOURS_UNIT_LONG : HOURS_UNIT_SHORT);
    wire lim_enabled = (lim_val_reg != '0);
    wire run_over_next = lim_enabled && (cumulative_run_hours_i > lim_hours);
    wire power_over_next = lim_enabled && (cumulative_power_hours_i > lim_hours);

    // ----------------------------------------------------------------
    // zero speed
    // ----------------------------------------------------------------
    wire [FREQ_W-1:0] zs_src = (curve_reg == CURVE_VEC) ? motor_speed_i : out_freq_i;
    wire zero_speed_next = (zs_src < zs_thr_reg);

    // ----------------------------------------------------------------
    // over-torque: quadrant from direction and torque sign
    // ----------------------------------------------------------------
    wire        tq_neg = torque_i[15];
    wire [15:0] tq_mag = tq_neg ? 16'(-torque_i) : 16'(torque_i);
    // index order: fwd power, rev regen, rev power, fwd regen
    wire [1:0]  quad = !reverse_i ? (tq_neg ? 2'h3 : 2'h0) : (tq_neg ? 2'h2 : 2'h1);
    wire        vec_curve = (curve_reg == CURVE_SLV) || (curve_reg == CURVE_SLV0) ||
                            (curve_reg == CURVE_VEC);
    // held low outside vector curves so the pin never shows noise
    wire overtorque_next = vec_curve &&
                           (tq_mag > {8'h00, tq_lim_reg[quad]});

    // ----------------------------------------------------------------
    // trip code and terminal mux
    // ----------------------------------------------------------------
    logic [3:0] code_next;

    dso_trip_encoder u_enc (
        .tripped_i (tripped_i),
        .factor_i  (trip_factor_i),
        .width_i   (trip_w_reg),
        .code_o    (code_next)
    );

    wire [4:0] flags_next = {tripped_i, overtorque_next, zero_speed_next,
                             power_over_next, run_over_next};
    logic [NTERM-1:0] term_next;

    // trip code overrides the low terminals in 3- and 4-bit modes
    generate
        for (gi = 0; gi < NTERM; gi++) begin : g_term
            if (gi < 3) begin : g_ac3
                assign term_next[gi] = (trip_w_reg == TW_3BIT || trip_w_reg == TW_4BIT) ?
                    code_next[gi] : pick(sel_reg[gi], flags_next);
            end else if (gi == 3) begin : g_ac4
                assign term_next[gi] = (trip_w_reg == TW_4BIT) ?
                    code_next[gi] : pick(sel_reg[gi], flags_next);
            end else begin : g_plain
                assign term_next[gi] = pick(sel_reg[gi], flags_next);
            end
        end
    endgenerate

    // everything is sampled once per clock and pins only see flops
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            run_over_reg   <= 1'b0;
            power_over_reg <= 1'b0;
            zero_speed_reg <= 1'b0;
            overtorque_reg <= 1'b0;
            alarm_code_reg <= AC_NORMAL;
            term_reg       <= '0;
            relay_reg      <= 1'b0;
        end else begin
            run_over_reg   <= run_over_next;
            power_over_reg <= power_over_next;
            zero_speed_reg <= zero_speed_next;
            overtorque_reg <= overtorque_next;
            alarm_code_reg <= code_next;
            term_reg       <= term_next;
            relay_reg      <= pick(sel_reg[NSEL-1], flags_next);
        end
    end

    // ----------------------------------------------------------------
    // read mux; data valid only in the cycle after the strobe
    // ----------------------------------------------------------------
    logic [DW-1:0] rd_mux;
    always_comb begin
        rd_mux = '0;
        for (int k = 0; k < NSEL; k++) begin
            if (addr_i == ADDR_SEL_BASE + 8'(k) * ADDR_SEL_STRIDE)
                rd_mux = DW'(sel_reg[k]);
        end
        for (int k = 0; k < 4; k++) begin
            if (addr_i == ADDR_TQ_BASE + 8'(k) * ADDR_SEL_STRIDE)
                rd_mux = DW'(tq_lim_reg[k]);
        end
        if (addr_i == ADDR_HOURS_LIM)
            rd_mux = DW'({lim_unit_reg, 2'h0, lim_val_reg});
        if (addr_i == ADDR_ZS_THR) rd_mux = DW'(zs_thr_reg);
        if (addr_i == ADDR_CURVE) rd_mux = DW'(curve_reg);
        if (addr_i == ADDR_TRIP_W) rd_mux = DW'(trip_w_reg);
        if (addr_i == ADDR_STATUS)
            rd_mux = DW'({alarm_code_reg, 2'h0, overtorque_reg, zero_speed_reg,
                          power_over_reg, run_over_reg, relay_reg, term_reg});
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) rdata_reg <= '0;
        else rdata_reg <= rd_i ? rd_mux : '0;
    end

    assign rdata_o = rdata_reg;
    assign term_o  = term_reg;
    assign relay_o = relay_reg;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);

    a_hours_zero_off: assert property (
        (lim_val_reg == '0) |=> (!run_over_reg && !power_over_reg))
        else $error("hours flags set with zero warning time");

    a_run_short_unit: assert property (
        (!lim_unit_reg && lim_val_reg != '0 &&
         cumulative_run_hours_i > HOURS_W'(lim_val_reg) * HOURS_UNIT_SHORT)
        |=> run_over_reg)
        else $error("run flag missing past ten-hour limit");

    a_power_long_unit: assert property (
        (lim_unit_reg && lim_val_reg != '0 &&
         cumulative_power_hours_i <= HOURS_W'(lim_val_reg) * HOURS_UNIT_LONG)
        |=> !power_over_reg)
        else $error("power flag set below hundred-hour limit");

    a_relay_route_ont: assert property (
        (sel_reg[NSEL-1] == FN_ONT) |=> (relay_o == power_over_reg))
        else $error("relay does not follow power flag");

    a_term4_route_rnt: assert property (
        (sel_reg[NTERM-1] == FN_RNT) |=> (term_o[NTERM-1] == run_over_reg))
        else $error("terminal 15 does not follow run flag");

    a_zs_source_sel: assert property (
        (curve_reg == CURVE_VEC && motor_speed_i < zs_thr_reg) ##1 1'b1
        |-> zero_speed_reg)
        else $error("zero speed missed on motor speed");

    a_zs_freq_source: assert property (
        (curve_reg != CURVE_VEC && out_freq_i < zs_thr_reg) |=> zero_speed_reg)
        else $error("zero speed missed on output frequency");

    a_zs_thr_range: assert property (
        zs_thr_reg <= ZS_THR_MAX)
        else $error("zero speed threshold above range");

    a_otq_off_curve: assert property (
        (!vec_curve) |=> !overtorque_reg)
        else $error("over-torque outside vector curves");

    a_otq_fwd_power: assert property (
        (vec_curve && !reverse_i && !torque_i[15] &&
         16'(torque_i) > {8'h00, tq_lim_reg[0]}) |=> overtorque_reg)
        else $error("forward powering over-torque missed");

    a_otq_rev_power: assert property (
        (vec_curve && reverse_i && torque_i[15] &&
         tq_mag > {8'h00, tq_lim_reg[2]}) |=> overtorque_reg)
        else $error("reverse powering over-torque missed");

    a_trip_override: assert property (
        (trip_w_reg == TW_4BIT) |=> (term_o[3:0] == alarm_code_reg))
        else $error("terminals do not carry 4-bit code");

    a_trip_disabled: assert property (
        (trip_w_reg == TW_OFF && sel_reg[0] == FN_RNT) |=> (term_o[0] == run_over_reg))
        else $error("terminal 11 ignores its selector");

    c_run_over_rise: cover property ($rose(run_over_reg));
    c_otq_rise: cover property ($rose(overtorque_reg));
    c_code3_other: cover property (trip_w_reg == TW_3BIT && alarm_code_reg == AC_OTHER3);
    c_zero_speed: cover property (zero_speed_reg && curve_reg == CURVE_VEC);

endmodule // dso_status_outputs

`default_nettype wire

// [include/dso_pkg.sv]
package dso_pkg;

    // ----------------------------------------------------------------
    // register bus geometry
    // ----------------------------------------------------------------
    localparam int AW = 8;
    localparam int DW = 32;

    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_SEL_BASE   = 8'h00;   // five terminals then relay
    localparam logic [7:0] ADDR_SEL_STRIDE = 8'h04;
    localparam logic [7:0] ADDR_HOURS_LIM  = 8'h18;
    localparam logic [7:0] ADDR_ZS_THR     = 8'h1c;
    localparam logic [7:0] ADDR_TQ_BASE    = 8'h20;   // fwd power, rev regen, rev power, fwd regen
    localparam logic [7:0] ADDR_CURVE      = 8'h30;
    localparam logic [7:0] ADDR_TRIP_W     = 8'h34;
    localparam logic [7:0] ADDR_STATUS     = 8'h38;

    // ----------------------------------------------------------------
    // field widths, positions and limits
    // ----------------------------------------------------------------
    localparam int NTERM   = 5;
    localparam int NSEL    = 6;
    localparam int SEL_W   = 6;
    localparam int LIM_W   = 14;
    localparam int HOURS_W = 21;
    localparam int FREQ_W  = 16;
    localparam int TQ_W    = 8;
    localparam int UNIT_BIT = 16;
    localparam logic [HOURS_W-1:0] HOURS_UNIT_SHORT = 21'h00000a;  // 10 hours
    localparam logic [HOURS_W-1:0] HOURS_UNIT_LONG  = 21'h000064;  // 100 hours
    localparam logic [FREQ_W-1:0]  ZS_THR_MAX = 16'h2710;          // 100.00 Hz in 0.01 Hz
    localparam logic [TQ_W-1:0]    TQ_LIM_MAX = 8'hb4;             // 180 percent

    // ----------------------------------------------------------------
    // terminal function codes
    // ----------------------------------------------------------------
    localparam logic [SEL_W-1:0] FN_ALARM = 6'h05;
    localparam logic [SEL_W-1:0] FN_OTQ   = 6'h07;
    localparam logic [SEL_W-1:0] FN_RNT   = 6'h0b;
    localparam logic [SEL_W-1:0] FN_ONT   = 6'h0c;
    localparam logic [SEL_W-1:0] FN_ZS    = 6'h15;

    // ----------------------------------------------------------------
    // control curves and trip code widths
    // ----------------------------------------------------------------
    localparam logic [2:0] CURVE_VC   = 3'h0;
    localparam logic [2:0] CURVE_SLV  = 3'h3;
    localparam logic [2:0] CURVE_SLV0 = 3'h4;
    localparam logic [2:0] CURVE_VEC  = 3'h5;
    localparam logic [1:0] TW_OFF  = 2'h0;
    localparam logic [1:0] TW_3BIT = 2'h1;
    localparam logic [1:0] TW_4BIT = 2'h2;

    // ----------------------------------------------------------------
    // trip factor numbers and the codes they map to
    // ----------------------------------------------------------------
    localparam int TF_W = 7;
    localparam logic [6:0] TF_01 = 7'h01, TF_04 = 7'h04, TF_05 = 7'h05, TF_06 = 7'h06;
    localparam logic [6:0] TF_07 = 7'h07, TF_08 = 7'h08, TF_09 = 7'h09, TF_10 = 7'h0a;
    localparam logic [6:0] TF_11 = 7'h0b, TF_12 = 7'h0c, TF_13 = 7'h0d, TF_14 = 7'h0e;
    localparam logic [6:0] TF_15 = 7'h0f, TF_16 = 7'h10, TF_20 = 7'h14, TF_21 = 7'h15;
    localparam logic [6:0] TF_23 = 7'h17, TF_24 = 7'h18, TF_25 = 7'h19, TF_29 = 7'h1d;
    localparam logic [6:0] TF_30 = 7'h1e, TF_35 = 7'h23, TF_36 = 7'h24, TF_38 = 7'h26;
    localparam logic [6:0] TF_43 = 7'h2b, TF_45 = 7'h2d, TF_50 = 7'h32, TF_79 = 7'h4f;
    localparam logic [3:0] AC_NORMAL = 4'h0;
    localparam logic [3:0] AC_OTHER3 = 4'h7;   // catch-all of the 3-bit code

endpackage

// [rtl/dso_trip_encoder.sv]
`timescale 1ns/1ps
`default_nettype none

// maps the latched trip factor to the 3- or 4-bit alarm code
module dso_trip_encoder (
    // trip state
    input  wire logic                      tripped_i,
    input  wire logic [dso_pkg::TF_W-1:0]  factor_i,
    input  wire logic [1:0]                width_i,
    // alarm code
    output logic      [3:0]                code_o
);
    import dso_pkg::*;

    logic [3:0] code4;
    logic [3:0] code3;

    // ----------------------------------------------------------------
    // 4-bit table
    // ----------------------------------------------------------------
    always_comb begin
        code4 = AC_NORMAL;
        if (factor_i >= TF_01 && factor_i <= TF_04) code4 = 4'h1;
        else if (factor_i == TF_05 || factor_i == TF_38) code4 = 4'h2;
        else if (factor_i == TF_07 || factor_i == TF_15) code4 = 4'h3;
        else if (factor_i == TF_09) code4 = 4'h4;
        else if (factor_i == TF_16) code4 = 4'h5;
        else if (factor_i == TF_30) code4 = 4'h6;
        else if (factor_i == TF_06) code4 = 4'h7;
        else if (factor_i == TF_08 || factor_i == TF_11 || factor_i == TF_23 ||
                 factor_i == TF_25 || factor_i == TF_29) code4 = 4'h8;
        else if (factor_i == TF_10) code4 = 4'h9;
        else if (factor_i == TF_12 || factor_i == TF_13 || factor_i == TF_35 ||
                 factor_i == TF_36) code4 = 4'ha;
        else if (factor_i == TF_14) code4 = 4'hb;
        else if (factor_i >= TF_43 && factor_i <= TF_45) code4 = 4'hc;
        else if (factor_i == TF_20 || factor_i == TF_21) code4 = 4'hd;
        else if (factor_i == TF_24) code4 = 4'he;
        else if (factor_i >= TF_50 && factor_i <= TF_79) code4 = 4'hf;
    end

    // ----------------------------------------------------------------
    // 3-bit folding: low-speed overload joins "other"
    // ----------------------------------------------------------------
    assign code3 = (code4 >= 4'h1 && code4 <= 4'h6 && factor_i != TF_38) ? code4 :
                   AC_OTHER3;

    // all-zero means normal; nothing shown until a trip is latched
    assign code_o = !tripped_i            ? AC_NORMAL :
                    (width_i == TW_4BIT)  ? code4 :
                    (width_i == TW_3BIT)  ? code3 : AC_NORMAL;

endmodule // dso_trip_encoder

`default_nettype wire

// [dv/dso_term_reader.sv]
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// far side: controller polling the terminals and the relay
// ----------------------------------------------------------------
module dso_term_reader (
    // clock and reset
    input  wire logic       clock_i,
    input  wire logic       nrst_i,
    // sensed contacts
    input  wire logic [4:0] term_i,
    input  wire logic       relay_i,
    // last polled word, relay on top
    output logic      [5:0] seen_o
);
    // polls once a cycle, so it lags the pins by one edge
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) seen_o <= 6'h00;
        else         seen_o <= {relay_i, term_i};
    end
endmodule // dso_term_reader

`default_nettype wire

// [dv/drive_status_output_signals_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none

module drive_status_output_signals_tb_top;
    import dso_pkg::*;
    logic clock_i = 0, nrst_i = 0, wr_i = 0, rd_i = 0, rev = 0, trip = 0;
    logic [7:0]  addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0, rdata_o;
    logic [15:0] ofq = 16'h0, msp = 16'h0, tq = 16'h0;
    logic [20:0] run_h = 21'h0, pwr_h = 21'h0;
    logic [6:0]  fac = 7'h00;
    logic [4:0]  term_o;
    logic        relay_o;
    logic [5:0]  seen;
    int errors = 0, samples_checked = 0;

    initial forever #50 clock_i = ~clock_i;

    dso_status_outputs i_dut (.clock_i(clock_i), .nrst_i(nrst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .out_freq_i(ofq),
        .motor_speed_i(msp), .torque_i(tq), .reverse_i(rev), .cumulative_run_hours_i(run_h),
        .cumulative_power_hours_i(pwr_h), .tripped_i(trip), .trip_factor_i(fac),
        .term_o(term_o), .relay_o(relay_o));
    dso_term_reader i_rd (.clock_i(clock_i), .nrst_i(nrst_i), .term_i(term_o),
        .relay_i(relay_o), .seen_o(seen));

    // ----------------------------------------------------------------
    // access and compare tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        wr_i    <= 1;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge clock_i);
        wr_i <= 0;
    endtask
    // returns on a rising edge so that callers drive inputs on the edge
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock_i);
        rd_i   <= 1;
        addr_i <= a;
        @(posedge clock_i);
        rd_i <= 0;
        #1 chk(rdata_o, exp);
        @(posedge clock_i);
    endtask
    // settle through the output register and the poller
    task automatic pins(input logic [5:0] exp);
        repeat (4) @(posedge clock_i);
        #1 chk({26'h0, seen}, {26'h0, exp});
        @(posedge clock_i);
    endtask
    task automatic report_and_stop;
        $display("checked %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // trip table: width, factor, expected pins
    logic [1:0] tw [5] = '{TW_4BIT, TW_4BIT, TW_3BIT, TW_3BIT, TW_3BIT};
    logic [6:0] tf [5] = '{TF_10, TF_79, TF_38, TF_05, TF_16};
    logic [5:0] te [5] = '{6'h09, 6'h0f, 6'h07, 6'h02, 6'h05};

    initial begin
        repeat (12) @(posedge clock_i);
        nrst_i <= 1;
        wr(8'hfc, 32'h1);
        rd(8'hfc, 32'h0);
        rd(ADDR_STATUS, 32'h0);
        // hours flags, short unit then disabled; terminals 11 and 15 both run flag
        wr(8'h00, 32'h0b);
        wr(8'h10, 32'h0b);
        wr(8'h14, 32'h0c);
        wr(8'h18, 32'h1);
        run_h <= 11;
        pwr_h <= 10;
        pins(6'h11);
        run_h <= 10;
        pwr_h <= 11;
        pins(6'h20);
        run_h <= 11;
        wr(8'h18, 32'h0);
        pins(6'h00);
        // long unit
        wr(8'h18, 32'h103e8);
        run_h <= 100000;
        pwr_h <= 100000;
        pins(6'h00);
        run_h <= 100001;
        pwr_h <= 100001;
        pins(6'h31);
        $display("hours test done");
        run_h <= 0;
        pwr_h <= 0;
        wr(8'h04, 32'h15);
        wr(8'h1c, 32'h4e20);
        rd(8'h1c, 32'h2710);
        wr(8'h1c, 32'h1388);
        wr(8'h30, 32'h0);
        ofq <= 4999;
        msp <= 6000;
        pins(6'h02);
        wr(8'h30, 32'h5);
        pins(6'h00);
        msp <= 4999;
        pins(6'h02);
        $display("speed test done");
        ofq <= 6000;
        msp <= 6000;
        wr(8'h30, 32'h3);
        wr(8'h08, 32'h07);
        wr(8'h20, 32'h64);
        wr(8'h24, 32'h12c);
        rd(8'h24, 32'hb4);
        tq <= 101;
        pins(6'h04);
        rd(ADDR_STATUS, 32'h204);
        tq <= 100;
        pins(6'h00);
        tq <= 101;
        rev <= 1;
        pins(6'h00);
        tq <= 16'hff9b;
        pins(6'h04);
        tq <= 101;
        $display("torque test done");
        trip <= 1;
        for (int i = 0; i < 5; i++) begin
            wr(8'h34, {30'h0, tw[i]});
            fac <= tf[i];
            pins(te[i]);
        end
        rd(ADDR_STATUS, 32'h5005);
        wr(8'h34, 32'h0);
        pins(6'h00);
        wr(8'h00, 32'h05);
        pins(6'h01);
        $display("trip test done");
        report_and_stop();
    end
endmodule // drive_status_output_signals_tb_top

`default_nettype wire
